// >>> rtl/wss_map.svh
// Register offsets, field positions, reset values and counts of the waveform state sequencer
`ifndef WSS_MAP_SVH
`define WSS_MAP_SVH
// ==========================================================
// Register byte offsets
`define WSS_CTRL_OFS 8'h00
`define WSS_STATUS_OFS 8'h04
`define WSS_IDLE_OFS 8'h08
`define WSS_TCOUNT_OFS 8'h0c
`define WSS_DATA_OFS 8'h10
`define WSS_ADDR_OFS 8'h14
`define WSS_INSTR_BASE 8'h20
`define WSS_INSTR_LAST 8'h38
// ==========================================================
// Control register fields
`define WSS_CTRL_TRIG 0
`define WSS_CTRL_TRICTL 1
`define WSS_CTRL_CNT_RDY5 2
`define WSS_CTRL_FW_READY 3
`define WSS_CTRL_FLGSEL_LSB 4
`define WSS_CTRL_IDLE_DRIVE 6
// ==========================================================
// Reset values and codes
`define WSS_CTRL_RST 7'h00
`define WSS_IDLE_RST 8'h3f
`define WSS_TCOUNT_RST 16'h0000
`define WSS_INSTR_RST 32'h0000_0000
`define WSS_STATE_COUNT 7
`define WSS_SEL_FLAG 3'h6
`define WSS_SEL_FW 3'h7
`define WSS_SEL_RDY5 3'h5
`define WSS_RESP_OKAY 2'h0
`define WSS_RESP_SLVERR 2'h2
`endif

// >>> rtl/wss_pkg.sv
// Types shared by the waveform state sequencer
package wss_pkg;
  // ==========================================================
  // Sequencer states; code 7 is the idle state
  typedef enum logic [2:0] {
    WSS_S0 = 3'b000,
    WSS_S1 = 3'b001,
    WSS_S2 = 3'b010,
    WSS_S3 = 3'b011,
    WSS_S4 = 3'b100,
    WSS_S5 = 3'b101,
    WSS_S6 = 3'b110,
    WSS_IDLE = 3'b111
  } wss_state_t;

  // Operation code byte
  typedef struct packed {
    logic [1:0] unused;
    logic sgl;
    logic gint;
    logic incad;
    logic next;
    logic data;
    logic dp;
  } wss_opcode_t;

  // Branch byte of a decision state
  typedef struct packed {
    logic reexec;
    logic unused;
    logic [2:0] on_one;
    logic [2:0] on_zero;
  } wss_branch_t;

  // Logic function byte of a decision state
  typedef struct packed {
    logic [1:0] logic_op_select;
    logic [2:0] decision_input_a;
    logic [2:0] decision_input_b;
  } wss_logic_t;

  // One four-byte state instruction, first byte in the low bits
  typedef struct packed {
    logic [7:0] outputs;
    wss_logic_t logic_fn;
    wss_opcode_t opcode;
    logic [7:0] len_branch;
  } wss_instr_t;
endpackage

// >>> rtl/wss_sequencer.sv
// Waveform state sequencer with an AXI4-Lite register port
//
// Notes on behaviour
// - All seven states fixed-length: after S6 go to idle without a branch.
// - Idle waits; a new waveform starts only on a firmware trigger.
// - Fewer than seven states: last used state must branch to idle itself.
// - Fixed-length states hold outputs for a programmed count of clock cycles.
// - Decision state samples two selected inputs, combines them, branches, maybe to itself.
// - A state's control task runs exactly once on entry.
// - Re-execute option repeats the task on each self-loop of a decision state.
// - Inputs: six ready lines, one FIFO flag, firmware ready, count expired for ready five.
// - Combining function is AND, OR or XOR.
// - Decision state holds a target for result one and one for zero.
// - Decision state lasts at least one cycle; branch on the following edge.
// - Instruction bytes: branch/length, operation code, logic function, outputs.
// - Instruction bytes read differently for decision and fixed-length states.
// - Length zero means 256 cycles.
// - Input select codes 0-5 ready lines, 6 FIFO flag, 7 firmware ready.
// - Top bit of the branch byte enables re-execution in decision states.
// - Waveform ends only on entering idle; only then may another start.
`timescale 1ns/1ps
`include "wss_map.svh"
module wss_sequencer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral side
  input wire logic [5:0] ready_input_n,
  input wire logic [2:0] fifo_flags,
  input wire logic [15:0] fifo_head,
  output logic [15:0] parallel_data_bus,
  output logic parallel_data_oe_n,
  output logic [5:0] control_outputs,
  output logic [5:0] control_oe_n,
  output logic [8:0] address_outputs,
  output logic fifo_advance,
  output logic busy
);
  // ==========================================================
  // Register file and bus state
  wss_pkg::wss_instr_t instr [`WSS_STATE_COUNT];
  wss_pkg::wss_instr_t next_instr [`WSS_STATE_COUNT];
  logic [6:0] ctrl, next_ctrl;
  logic [7:0] idle_ctl, next_idle_ctl;
  logic [15:0] tcount, next_tcount;
  logic [15:0] out_word, next_out_word;
  logic trig_req, next_trig_req;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic addr_wr;
  logic [8:0] addr_wr_val;

  // Sequencer state
  wss_pkg::wss_state_t state, next_state;
  logic [7:0] len_cnt, next_len_cnt;
  logic [15:0] next_bus;
  logic next_bus_oe_n, next_advance, next_busy;
  logic [5:0] next_ctl, next_ctl_oe_n;
  logic [8:0] next_addr;
  logic tcount_dec;

  // Ready line synchronisers
  logic [5:0] rdy_s1, rdy_s2, rdy_s3, rdy_clean, next_rdy_clean;

  // Byte-lane merge for register writes
  function automatic logic [31:0] wss_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // AXI4-Lite slave: address and data taken in either order
  always_comb begin
    logic [31:0] merged;
    merged = '0;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    next_idle_ctl = idle_ctl;
    next_out_word = out_word;
    next_trig_req = trig_req;
    next_tcount = tcount;
    addr_wr = 1'b0;
    addr_wr_val = '0;
    for (int i = 0; i < `WSS_STATE_COUNT; i++) begin
      next_instr[i] = instr[i];
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    // Trigger is consumed only in idle; a trigger while busy is dropped
    if (trig_req && state == wss_pkg::WSS_IDLE) begin
      next_trig_req = 1'b0;
    end else if (state != wss_pkg::WSS_IDLE) begin
      next_trig_req = 1'b0;
    end
    // Count runs down on each FIFO advance; a reload write below wins
    if (tcount_dec && tcount != 16'h0000) begin
      next_tcount = tcount - 16'h0001;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `WSS_RESP_OKAY;
      merged = wss_merge({25'h0, ctrl}, w_data, w_strb);
      if (aw_addr[7:2] == `WSS_CTRL_OFS >> 2) begin
        next_ctrl = {merged[6:1], 1'b0};
        if (merged[`WSS_CTRL_TRIG] && state == wss_pkg::WSS_IDLE) begin
          next_trig_req = 1'b1;
        end
      end else if (aw_addr[7:2] == `WSS_IDLE_OFS >> 2) begin
        next_idle_ctl = 8'(wss_merge({24'h0, idle_ctl}, w_data, w_strb));
      end else if (aw_addr[7:2] == `WSS_TCOUNT_OFS >> 2) begin
        next_tcount = 16'(wss_merge({16'h0, tcount}, w_data, w_strb));
      end else if (aw_addr[7:2] == `WSS_DATA_OFS >> 2) begin
        next_out_word = 16'(wss_merge({16'h0, out_word}, w_data, w_strb));
      end else if (aw_addr[7:2] == `WSS_ADDR_OFS >> 2) begin
        addr_wr = 1'b1;
        addr_wr_val = w_data[8:0];
      end else if (aw_addr >= `WSS_INSTR_BASE && aw_addr <= `WSS_INSTR_LAST) begin
        next_instr[3'(aw_addr[4:2])] = wss_merge(instr[3'(aw_addr[4:2])], w_data, w_strb);
      end else if (aw_addr[7:2] != `WSS_STATUS_OFS >> 2) begin
        next_bresp = `WSS_RESP_SLVERR;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Write ready is low while a word is held or a response is pending
  assign next_awready = !next_aw_held && !next_bvalid;
  assign next_wready = !next_w_held && !next_bvalid;

  // Read channel: one cycle from address to data
  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = `WSS_RESP_OKAY;
      next_rdata = '0;
      if (s_axi_araddr[7:2] == `WSS_CTRL_OFS >> 2) begin
        next_rdata = {25'h0, ctrl};
      end else if (s_axi_araddr[7:2] == `WSS_STATUS_OFS >> 2) begin
        next_rdata = {19'h0, address_outputs, state, state == wss_pkg::WSS_IDLE};
      end else if (s_axi_araddr[7:2] == `WSS_IDLE_OFS >> 2) begin
        next_rdata = {24'h0, idle_ctl};
      end else if (s_axi_araddr[7:2] == `WSS_TCOUNT_OFS >> 2) begin
        next_rdata = {16'h0, tcount};
      end else if (s_axi_araddr[7:2] == `WSS_DATA_OFS >> 2) begin
        next_rdata = {16'h0, out_word};
      end else if (s_axi_araddr[7:2] == `WSS_ADDR_OFS >> 2) begin
        next_rdata = {23'h0, address_outputs};
      end else if (s_axi_araddr >= `WSS_INSTR_BASE && s_axi_araddr <= `WSS_INSTR_LAST) begin
        next_rdata = instr[3'(s_axi_araddr[4:2])];
      end else begin
        next_rresp = `WSS_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WSS_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `WSS_RESP_OKAY;
      ctrl <= `WSS_CTRL_RST;
      idle_ctl <= `WSS_IDLE_RST;
      tcount <= `WSS_TCOUNT_RST;
      out_word <= '0;
      trig_req <= 1'b0;
      for (int i = 0; i < `WSS_STATE_COUNT; i++) begin
        instr[i] <= `WSS_INSTR_RST;
      end
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      ctrl <= next_ctrl;
      idle_ctl <= next_idle_ctl;
      tcount <= next_tcount;
      out_word <= next_out_word;
      trig_req <= next_trig_req;
      for (int i = 0; i < `WSS_STATE_COUNT; i++) begin
        instr[i] <= next_instr[i];
      end
    end
  end

  // ==========================================================
  // Ready pins: a change counts once stages two and three agree
  assign next_rdy_clean = (rdy_s2 & rdy_s3) | (rdy_clean & (rdy_s2 | rdy_s3));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_s1 <= '0;
      rdy_s2 <= '0;
      rdy_s3 <= '0;
      rdy_clean <= '0;
    end else begin
      rdy_s1 <= ready_input_n;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
      rdy_clean <= next_rdy_clean;
    end
  end

  // ==========================================================
  // Decision input selection and logic function
  function automatic logic wss_pick(input logic [2:0] sel, input logic [5:0] rdy, input logic flag,
                                    input logic fw, input logic cnt_sub, input logic expired);
    logic res;
    res = 1'b0;
    if (sel == `WSS_SEL_FW) begin
      res = fw;
    end else if (sel == `WSS_SEL_FLAG) begin
      res = flag;
    end else if (sel == `WSS_SEL_RDY5 && cnt_sub) begin
      res = expired;
    end else begin
      res = rdy[sel];
    end
    return res;
  endfunction

  wss_pkg::wss_instr_t cur, nxt;
  wss_pkg::wss_branch_t br;
  logic flag_sel, term_a, term_b, result;

  // Preselected FIFO flag: 0 programmable, 1 empty, 2 and 3 full
  assign flag_sel = fifo_flags[ctrl[`WSS_CTRL_FLGSEL_LSB +: 2] > 2'h2 ? 2'h2 : ctrl[`WSS_CTRL_FLGSEL_LSB +: 2]];
  assign cur = (state == wss_pkg::WSS_IDLE) ? '0 : instr[state];
  assign nxt = (next_state == wss_pkg::WSS_IDLE) ? '0 : instr[next_state];
  assign br = cur.len_branch;
  assign term_a = wss_pick(cur.logic_fn.decision_input_a, rdy_clean, flag_sel, ctrl[`WSS_CTRL_FW_READY],
                           ctrl[`WSS_CTRL_CNT_RDY5], tcount == 16'h0000);
  assign term_b = wss_pick(cur.logic_fn.decision_input_b, rdy_clean, flag_sel, ctrl[`WSS_CTRL_FW_READY],
                           ctrl[`WSS_CTRL_CNT_RDY5], tcount == 16'h0000);

  // Codes 00 and 11 both mean AND
  always_comb begin
    unique case (cur.logic_fn.logic_op_select)
      2'h1: result = term_a | term_b;
      2'h2: result = term_a ^ term_b;
      default: result = term_a & term_b;
    endcase
  end

  // ==========================================================
  // Sequencer: next state and outputs of the state being entered
  always_comb begin
    logic enter;
    enter = 1'b0;
    next_state = state;
    next_len_cnt = len_cnt;
    if (state == wss_pkg::WSS_IDLE) begin
      if (trig_req) begin
        next_state = wss_pkg::WSS_S0;
        enter = 1'b1;
      end
    end else if (!cur.opcode.dp) begin
      if (len_cnt != 8'h00) begin
        next_len_cnt = len_cnt - 8'h01;
      end else begin
        enter = 1'b1;
        // No implied idle before S6; a short program must branch there itself
        next_state = (state == wss_pkg::WSS_S6) ? wss_pkg::WSS_IDLE
                     : wss_pkg::wss_state_t'(state + 3'h1);
      end
    end else begin
      // One cycle per evaluation, branch on the next edge
      next_state = wss_pkg::wss_state_t'(result ? br.on_one : br.on_zero);
      enter = (next_state != state) || br.reexec;
    end
    next_bus = parallel_data_bus;
    next_bus_oe_n = parallel_data_oe_n;
    next_ctl = control_outputs;
    next_ctl_oe_n = control_oe_n;
    next_addr = addr_wr ? addr_wr_val : address_outputs;
    next_advance = 1'b0;
    next_busy = next_state != wss_pkg::WSS_IDLE;
    tcount_dec = 1'b0;
    if (enter && next_state == wss_pkg::WSS_IDLE) begin
      // Idle drives the last word only when asked to
      next_bus_oe_n = !ctrl[`WSS_CTRL_IDLE_DRIVE];
      next_ctl = ctrl[`WSS_CTRL_TRICTL] ? {2'h0, idle_ctl[3:0]} : idle_ctl[5:0];
      next_ctl_oe_n = ctrl[`WSS_CTRL_TRICTL] ? {2'h3, ~idle_ctl[7:4]} : 6'h00;
    end else if (enter) begin
      // Task runs once here; a plain loop without re-execute skips it
      next_len_cnt = nxt.len_branch - 8'h01;
      next_addr = address_outputs + {8'h00, nxt.opcode.incad};
      next_advance = nxt.opcode.next && !nxt.opcode.sgl;
      tcount_dec = next_advance;
      next_bus_oe_n = !nxt.opcode.data;
      if (nxt.opcode.data) begin
        next_bus = nxt.opcode.sgl ? out_word : fifo_head;
      end
      next_ctl = ctrl[`WSS_CTRL_TRICTL] ? {2'h0, nxt.outputs[3:0]} : nxt.outputs[5:0];
      next_ctl_oe_n = ctrl[`WSS_CTRL_TRICTL] ? {2'h3, ~nxt.outputs[7:4]} : 6'h00;
    end
  end

  // Sequencer registers; reset lands in idle with idle outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= wss_pkg::WSS_IDLE;
      len_cnt <= 8'h00;
      parallel_data_bus <= 16'h0000;
      parallel_data_oe_n <= 1'b1;
      control_outputs <= 6'(`WSS_IDLE_RST);
      control_oe_n <= 6'h00;
      address_outputs <= 9'h000;
      fifo_advance <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      len_cnt <= next_len_cnt;
      parallel_data_bus <= next_bus;
      parallel_data_oe_n <= next_bus_oe_n;
      control_outputs <= next_ctl;
      control_oe_n <= next_ctl_oe_n;
      address_outputs <= next_addr;
      fifo_advance <= next_advance;
      busy <= next_busy;
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the waveform state sequencer
`timescale 1ns/1ps
module tb_top;
  // ==========================================
  // Signals
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, hold = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, parallel_data_oe_n, fifo_advance, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] ready_input_n, control_outputs, control_oe_n, rdy_base = '0;
  logic [2:0] fifo_flags, flg_set = '0;
  logic [15:0] fifo_head, parallel_data_bus;
  logic [8:0] address_outputs;
  int n_errors = 0, compares = 0, cyc = 0, bcnt = 0, acnt = 0, seed = 9;
  always #25 aclk = ~aclk;
  wss_sequencer uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ready_input_n, .fifo_flags,
    .fifo_head, .parallel_data_bus, .parallel_data_oe_n, .control_outputs, .control_oe_n, .address_outputs,
    .fifo_advance, .busy);
  wss_periph_model peer (.aclk, .aresetn, .rdy_base, .flg_set, .hold, .fifo_advance, .ready_input_n, .fifo_flags,
    .fifo_head);
  // Busy cycles, advances, and a hang guard at 20000 cycles, well above the fewer than a thousand cycles needed
  always @(posedge aclk) begin
    cyc++;
    if (busy === 1'b1) bcnt++;
    if (fifo_advance === 1'b1) acnt++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up;
    end
  end
  // ==========================================
  // Tasks
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Both write channels offered together, each released when taken; bready stands until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  // Address released when taken; rready stands until the data arrive
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // Trigger one waveform and wait for the return to idle
  task automatic run(input logic [31:0] ctrl);
    bcnt = 0;
    acnt = 0;
    wr(8'h00, ctrl | 32'h1, 2'h0);
    repeat (4) @(posedge aclk);
    // A hang is caught by the cycle guard, which counts it as a mismatch
    while (busy !== 1'b0) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask
  function automatic logic dec(input logic [1:0] lf, input logic a, input logic b);
    return (lf == 2'h1) ? (a | b) : (lf == 2'h2) ? (a ^ b) : (a & b);
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] ln;
    logic [2:0] sel;
    logic [1:0] lf, fs;
    logic fw, cs, b;
    logic [8:0] a0;
    int ex;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk({busy, parallel_data_oe_n, control_outputs}, {2'b01, 6'h3f});
    rd(8'h08, 32'h3f, 2'h0);
    rd(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'hffffffff, 2'h2);
    // All seven states fixed-length, one with the longest count
    ex = 0;
    for (int s = 0; s < 7; s++) begin
      ln = (s == 3) ? 8'h00 : 8'h01 + 8'($random(seed) & 3);
      ex += (ln == 8'h00) ? 256 : int'(ln);
      wr(8'h20 + 8'(4 * s), {2'b00, 6'($random(seed)), 8'h00, 8'h0a, ln}, 2'h0);
    end
    a0 = address_outputs;
    run(32'h0);
    chk(bcnt, ex);
    chk(9'(address_outputs - a0), 9'h7);
    repeat (20) @(posedge aclk);
    chk(busy, 1'b0);
    // Every select code, each with a random function; the result picks a one or two state path
    wr(8'h24, {8'h3f, 8'h00, 8'h01, 8'h3f}, 2'h0);
    for (int i = 0; i < 16; i++) begin
      sel = 3'(i);
      lf = 2'($random(seed));
      fw = 1'($random(seed));
      fs = 2'($random(seed));
      cs = i >= 8;
      rdy_base <= 6'($random(seed));
      flg_set <= 3'($random(seed));
      wr(8'h20, {8'h3f, lf, 3'h7, sel, 8'h01, 8'h0f}, 2'h0);
      repeat (6) @(posedge aclk);
      // Flag select: 0 programmable, 1 empty, 2 and 3 full
      b = (sel == 3'h7) ? fw : (sel == 3'h6) ? flg_set[(fs == 2'h3) ? 2'h2 : fs]
          : (sel == 3'h5 && cs) ? 1'b1 : rdy_base[sel];
      run({26'h0, fs, fw, cs, 2'b00});
      chk(bcnt, dec(lf, fw, b) ? 2 : 1);
    end
    // Self-looping decision state against a slow peripheral, with and without re-execution
    for (int r = 0; r < 2; r++) begin
      rdy_base <= 6'h01;
      hold <= 8'h0c;
      wr(8'h20, {8'h3f, 8'h00, 8'h0d, 1'(r), 7'h07}, 2'h0);
      repeat (6) @(posedge aclk);
      a0 = address_outputs;
      run(32'h0);
      chk(bcnt > 3, 1'b1);
      chk(acnt, r ? bcnt : 1);
      chk(9'(address_outputs - a0), acnt);
      hold <= 8'h00;
      repeat (2) @(posedge aclk);
    end
    // Single-data word on the bus, kept driven in idle; control pins in tri-state mode
    ex = $random(seed);
    wr(8'h10, ex, 2'h0);
    wr(8'h20, {8'h3f, 8'h00, 8'h22, 8'h01}, 2'h0);
    run(32'h42);
    chk({parallel_data_oe_n, parallel_data_bus}, {1'b0, 16'(ex)});
    chk({control_oe_n, control_outputs}, {6'h3c, 6'h0f});
    wrap_up;
  end
endmodule
bind wss_sequencer wss_seq_monitor mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .control_outputs, .parallel_data_oe_n,
  .fifo_advance, .busy);

// >>> tb/wss_periph_model.sv
// Behavioural peripheral: ready lines, FIFO flags and FIFO head word
`timescale 1ns/1ps
module wss_periph_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench controls
  input wire logic [5:0] rdy_base,
  input wire logic [2:0] flg_set,
  input wire logic [7:0] hold,
  // Sequencer side
  input wire logic fifo_advance,
  output logic [5:0] ready_input_n,
  output logic [2:0] fifo_flags,
  output logic [15:0] fifo_head
);
  logic [7:0] cnt;
  // A slow peripheral takes hold cycles after the first word, then drops ready line zero
  always @(posedge aclk) begin
    if (!aresetn || hold == 8'h00) cnt <= 8'h00;
    else if ((fifo_advance || cnt != 8'h00) && cnt < hold) cnt <= cnt + 8'h01;
    if (!aresetn) fifo_head <= 16'h0000;
    else if (fifo_advance) fifo_head <= fifo_head + 16'h1357;
  end
  // Lines are always driven, so no released-line pattern is needed
  assign ready_input_n = {rdy_base[5:1], rdy_base[0] && !(hold != 8'h00 && cnt >= hold)};
  assign fifo_flags = flg_set;
endmodule

// >>> tb/wss_seq_monitor.sv
// Concurrent checks on the sequencer's register port and waveform outputs
`timescale 1ns/1ps
module wss_seq_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register port
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Waveform side
  input wire logic [5:0] control_outputs,
  input wire logic parallel_data_oe_n,
  input wire logic fifo_advance,
  input wire logic busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Trigger age
  logic [3:0] age;
  logic [3:0] next_age;
  // Saturates so that an old trigger can never excuse a late start
  always_comb begin
    next_age = (age == 4'hf) ? age : age + 4'h1;
    if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00 && s_axi_wdata[0])
      next_age = 4'h0;
  end
  always_ff @(posedge aclk) begin
    age <= aresetn ? next_age : 4'hf;
  end
  // ==========================================
  // Assertions
  a_reset_idle: assert property (disable iff (1'b0)
    !aresetn |=> !busy && !fifo_advance && parallel_data_oe_n && control_outputs == 6'h3f)
    else $error("outputs not idle after reset");
  a_start_bound: assert property ($rose(busy) |-> age <= 4'h5)
    else $error("waveform started without a trigger");
  a_adv_in_wave: assert property (fifo_advance |-> busy || $past(busy))
    else $error("fifo advanced outside a waveform");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response repeated");
  a_aw_reopen: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channels not reopened");
  c_trigger: cover property ($rose(busy));
  c_burst: cover property (fifo_advance ##1 fifo_advance);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
